// ### rtl/setpoint_access_menu.sv
// Purpose: front panel setpoint access menu with wishbone registers
// Assumes: buttons are synchronous, debounced levels, high when pressed
// Notes:   menu store to a setpoint wins over a bus write the same cycle
// Functional notes
// RULE1: select plus up enters access menu
// RULE2: no code protection shows first setpoint prompt
// RULE3: protected: code prompt, select starts entry
// RULE4: code entry: up/down change digit, right advances
// RULE5: matching code plus enter shows first prompt
// RULE6: up or down toggles between setpoint prompts
// RULE7: wrong code or 20 s idle returns
// RULE8: select edits stored setpoint digit by digit
// RULE9: enter stores; enter again returns to display
// RULE10: key combination works only when access enabled
// RULE11: bargraph format shows value with setpoints
// RULE12: regions beyond setpoints lit, value single bar
// RULE13: value bar flashes next to setpoint region
// RULE14: value equal setpoint flashes whole region
// RULE15: format valid: low, high, first below second
// RULE16: invalid format flashes scale, no bars
// RULE17: separate four digit decimal access code
// RULE18: code all zeros disables the check
// RULE19: idle seconds restart on each press
//
// The Wishbone register port and the register addresses were decided locally.
`timescale 1ns/100ps
module setpoint_access_menu #(
  parameter int unsigned SEC_CYCLES   = setpoint_pkg::SEC_CYCLES,
  parameter int unsigned BLINK_CYCLES = setpoint_pkg::BLINK_CYCLES,
  parameter int unsigned SEGS         = setpoint_pkg::SEGS
) (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  input  wire logic            wb_we_i,
  input  wire logic [4:0]      wb_adr_i,
  input  wire logic [3:0]      wb_sel_i,
  input  wire logic [31:0]     wb_dat_i,
  output logic      [31:0]     wb_dat_o,
  output logic                 wb_ack_o,
  input  wire logic            btn_select_i,
  input  wire logic            btn_up_i,
  input  wire logic            btn_down_i,
  input  wire logic            btn_right_i,
  input  wire logic            btn_enter_i,
  input  wire logic [15:0]     value_i,
  output logic      [2:0]      menu_state_o,
  output logic      [15:0]     disp_value_o,
  output logic      [1:0]      flash_digit_o,
  output logic                 edit_active_o,
  output logic      [SEGS-1:0] bar_o,
  output logic                 scale_on_o
);
  if (SEC_CYCLES < 2 || BLINK_CYCLES < 2) $error("divider count too short");
  // packed decimal digit step, position 0 is the leftmost digit
  function automatic logic [15:0] bump(input logic [15:0] v,
                                       input logic [1:0]  pos,
                                       input logic        inc);
    logic [3:0] d;
    logic [4:0] sh;
    sh = {1'b0, ~pos, 2'b00};
    d  = 4'(v >> sh);
    if (inc) d = (d >= 4'h9) ? 4'h0 : d + 4'h1;
    else     d = (d == 4'h0) ? 4'h9 : d - 4'h1;
    return (v & ~(16'h000f << sh)) | (16'(d) << sh);
  endfunction
  logic [4:0]  ctrl;
  logic [15:0] code;
  logic [15:0] sp1;
  logic [15:0] sp2;
  logic [4:0]  next_ctrl;
  logic [15:0] next_code;
  logic [15:0] next_sp1;
  logic [15:0] next_sp2;
  logic [31:0] next_dat;
  logic        next_ack;
  logic        bus_wr;
  setpoint_pkg::menu_state_t state;
  setpoint_pkg::menu_state_t next_state;
  logic        sel;
  logic        next_sel;
  logic [15:0] ebuf;
  logic [15:0] next_ebuf;
  logic [1:0]  digit;
  logic [1:0]  next_digit;
  logic [4:0]  idle_s;
  logic [4:0]  next_idle_s;
  logic [31:0] sec_cnt;
  logic [31:0] next_sec_cnt;
  logic [4:0]  prev_btn;
  logic [4:0]  btn;
  logic [4:0]  press;
  logic        any_press;
  logic        combo;
  logic        timeout;
  logic        store;
  logic [31:0] blink_cnt;
  logic [31:0] next_blink_cnt;
  logic        blink;
  logic        next_blink;
  // button edges, order: enter right down up select
  always_comb begin
    btn       = {btn_enter_i, btn_right_i, btn_down_i, btn_up_i, btn_select_i};
    press     = btn & ~prev_btn;
    any_press = |press;
    combo     = btn_select_i & btn_up_i & (press[0] | press[1]); // [RULE1]
    timeout   = (state != setpoint_pkg::ST_DISPLAY) && !any_press
              && idle_s >= 5'(setpoint_pkg::TIMEOUT_S);         // [RULE7]
    store     = (state == setpoint_pkg::ST_SP_EDIT) && press[4]; // [RULE9]
  end
  // wishbone slave, one wait cycle, unmapped reads zero
  always_comb begin
    bus_wr    = wb_cyc_i & wb_stb_i & wb_we_i & !wb_ack_o;
    next_ack  = wb_cyc_i & wb_stb_i & !wb_ack_o;
    next_ctrl = ctrl;
    next_code = code;
    next_sp1  = sp1;
    next_sp2  = sp2;
    next_dat  = 32'h0000_0000;
    if (bus_wr) begin
      case (wb_adr_i)
        setpoint_pkg::OFS_CTRL:
          if (wb_sel_i[0]) next_ctrl = wb_dat_i[4:0];
        setpoint_pkg::OFS_CODE: begin // [RULE17]
          if (wb_sel_i[0]) next_code[7:0]  = wb_dat_i[7:0];
          if (wb_sel_i[1]) next_code[15:8] = wb_dat_i[15:8];
        end
        setpoint_pkg::OFS_SP1: begin
          if (wb_sel_i[0]) next_sp1[7:0]  = wb_dat_i[7:0];
          if (wb_sel_i[1]) next_sp1[15:8] = wb_dat_i[15:8];
        end
        setpoint_pkg::OFS_SP2: begin
          if (wb_sel_i[0]) next_sp2[7:0]  = wb_dat_i[7:0];
          if (wb_sel_i[1]) next_sp2[15:8] = wb_dat_i[15:8];
        end
        default: ;
      endcase
    end
    if (store && !sel) next_sp1 = ebuf; // [RULE9]
    if (store && sel)  next_sp2 = ebuf; // [RULE9]
    case (wb_adr_i)
      setpoint_pkg::OFS_CTRL:   next_dat = 32'(ctrl);
      setpoint_pkg::OFS_CODE:   next_dat = 32'(code);
      setpoint_pkg::OFS_SP1:    next_dat = 32'(sp1);
      setpoint_pkg::OFS_SP2:    next_dat = 32'(sp2);
      setpoint_pkg::OFS_STATUS: begin
        next_dat[setpoint_pkg::ST_STATE_LSB +: 3] = 3'(state);
        next_dat[setpoint_pkg::ST_SEL_BIT]        = sel;
        next_dat[setpoint_pkg::ST_DIG_LSB +: 2]   = digit;
        next_dat[setpoint_pkg::ST_BUF_LSB +: 16]  = ebuf;
      end
      default:                  next_dat = 32'h0000_0000;
    endcase
  end
  // register file and bus answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl     <= setpoint_pkg::CTRL_RST;
      code     <= setpoint_pkg::CODE_RST;
      sp1      <= setpoint_pkg::SP_RST;
      sp2      <= setpoint_pkg::SP_RST;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ctrl     <= next_ctrl;
      code     <= next_code;
      sp1      <= next_sp1;
      sp2      <= next_sp2;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end
  // menu sequencing, idle seconds and blink timebase
  always_comb begin
    next_state     = state;
    next_sel       = sel;
    next_ebuf      = ebuf;
    next_digit     = digit;
    next_idle_s    = idle_s;
    next_sec_cnt   = sec_cnt + 32'h1;
    next_blink_cnt = blink_cnt + 32'h1;
    next_blink     = blink;
    if (blink_cnt >= 32'(BLINK_CYCLES - 1)) begin
      next_blink_cnt = 32'h0;
      next_blink     = !blink;
    end
    if (sec_cnt >= 32'(SEC_CYCLES - 1)) begin
      next_sec_cnt = 32'h0;
      next_idle_s  = idle_s + 5'h1; // [RULE19]
    end
    if (any_press || state == setpoint_pkg::ST_DISPLAY) begin
      next_sec_cnt = 32'h0; // [RULE19]
      next_idle_s  = 5'h0;
    end
    case (state)
      setpoint_pkg::ST_DISPLAY:
        if (combo && ctrl[setpoint_pkg::CTRL_ACCESS]) begin // [RULE10]
          next_sel = 1'b0;
          if (code == setpoint_pkg::CODE_RST)
            next_state = setpoint_pkg::ST_SP_PROMPT; // [RULE2] [RULE18]
          else
            next_state = setpoint_pkg::ST_CODE_PROMPT; // [RULE3]
        end
      setpoint_pkg::ST_CODE_PROMPT:
        if (press[0]) begin // [RULE3]
          next_state = setpoint_pkg::ST_CODE_EDIT;
          next_ebuf  = 16'h0000;
          next_digit = 2'h0;
        end
      setpoint_pkg::ST_CODE_EDIT, setpoint_pkg::ST_SP_EDIT: begin
        if (press[1])      next_ebuf  = bump(ebuf, digit, 1'b1); // [RULE4]
        else if (press[2]) next_ebuf  = bump(ebuf, digit, 1'b0); // [RULE8]
        if (press[3])      next_digit = digit + 2'h1;            // [RULE4]
        if (press[4] && state == setpoint_pkg::ST_SP_EDIT)
          next_state = setpoint_pkg::ST_SP_PROMPT;                // [RULE9]
        else if (press[4] && ebuf == code) begin
          next_state = setpoint_pkg::ST_SP_PROMPT;                // [RULE5]
          next_sel   = 1'b0;
        end else if (press[4])
          next_state = setpoint_pkg::ST_DISPLAY;                  // [RULE7]
      end
      setpoint_pkg::ST_SP_PROMPT:
        if (press[4])
          next_state = setpoint_pkg::ST_DISPLAY; // [RULE9]
        else if (press[0]) begin                 // [RULE8]
          next_state = setpoint_pkg::ST_SP_EDIT;
          next_ebuf  = sel ? sp2 : sp1;
          next_digit = 2'h0;
        end else if (press[1] || press[2])
          next_sel = !sel; // [RULE6]
      default: next_state = setpoint_pkg::ST_DISPLAY;
    endcase
    if (timeout) next_state = setpoint_pkg::ST_DISPLAY; // [RULE7]
  end
  // menu state registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state     <= setpoint_pkg::ST_DISPLAY;
      sel       <= 1'b0;
      ebuf      <= 16'h0000;
      digit     <= 2'h0;
      idle_s    <= 5'h0;
      sec_cnt   <= 32'h0;
      prev_btn  <= 5'h1f;
      blink_cnt <= 32'h0;
      blink     <= 1'b0;
    end else begin
      state     <= next_state;
      sel       <= next_sel;
      ebuf      <= next_ebuf;
      digit     <= next_digit;
      idle_s    <= next_idle_s;
      sec_cnt   <= next_sec_cnt;
      prev_btn  <= btn;
      blink_cnt <= next_blink_cnt;
      blink     <= next_blink;
    end
  end

  // display drive: edit buffer while editing, else live value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      menu_state_o  <= 3'h0;
      disp_value_o  <= 16'h0000;
      flash_digit_o <= 2'h0;
      edit_active_o <= 1'b0;
    end else begin
      menu_state_o  <= 3'(next_state);
      disp_value_o  <= (next_state == setpoint_pkg::ST_CODE_EDIT ||
                        next_state == setpoint_pkg::ST_SP_EDIT) ?
                       next_ebuf : value_i;
      flash_digit_o <= next_digit;
      edit_active_o <= next_state == setpoint_pkg::ST_CODE_EDIT ||
                       next_state == setpoint_pkg::ST_SP_EDIT;
    end
  end

  setpoint_bargraph #(
    .SEGS(SEGS)
  ) u_bar (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .value_i    (value_i),
    .lo_i       (sp1),
    .hi_i       (sp2),
    .a1_low_i   (ctrl[setpoint_pkg::CTRL_A1_LOW]),
    .a2_high_i  (ctrl[setpoint_pkg::CTRL_A2_HIGH]),
    .fmt_lo_i   (ctrl[setpoint_pkg::CTRL_FMT_LO]),
    .fmt_hi_i   (ctrl[setpoint_pkg::CTRL_FMT_HI]),
    .blink_i    (blink),
    .bar_o      (bar_o),
    .scale_on_o (scale_on_o)
  );

  // checks on the menu sequence
  a_open_plain: assert property (@(posedge clk_i) // [RULE2] [RULE18]
    disable iff (rst_i) state == setpoint_pkg::ST_DISPLAY && combo &&
    ctrl[0] && code == 16'h0 |=> state == setpoint_pkg::ST_SP_PROMPT && !sel)
    else $error("plain open did not reach first prompt");
  a_open_locked: assert property (@(posedge clk_i) // [RULE1] [RULE3]
    disable iff (rst_i) state == setpoint_pkg::ST_DISPLAY && combo &&
    ctrl[0] && code != 16'h0 |=> state == setpoint_pkg::ST_CODE_PROMPT)
    else $error("protected open did not show code prompt");
  a_combo_off: assert property (@(posedge clk_i) // [RULE10]
    disable iff (rst_i) state == setpoint_pkg::ST_DISPLAY && !ctrl[0]
    |=> state == setpoint_pkg::ST_DISPLAY)
    else $error("menu opened while access disabled");
  a_code_right: assert property (@(posedge clk_i) // [RULE4]
    disable iff (rst_i) state == setpoint_pkg::ST_CODE_EDIT && !timeout
    && press == 5'h08 |=> digit == $past(digit) + 2'h1 && ebuf == $past(ebuf))
    else $error("right press did not advance digit");
  a_code_match: assert property (@(posedge clk_i) // [RULE5]
    disable iff (rst_i) state == setpoint_pkg::ST_CODE_EDIT && press[4] &&
    ebuf == code && !timeout |=> state == setpoint_pkg::ST_SP_PROMPT)
    else $error("good code refused");
  a_code_wrong: assert property (@(posedge clk_i) // [RULE7]
    disable iff (rst_i) state == setpoint_pkg::ST_CODE_EDIT && press[4] &&
    ebuf != code |=> state == setpoint_pkg::ST_DISPLAY)
    else $error("wrong code accepted");
  a_prompt_swap: assert property (@(posedge clk_i) // [RULE6]
    disable iff (rst_i) state == setpoint_pkg::ST_SP_PROMPT && !timeout
    && (press == 5'h02 || press == 5'h04) |=> sel != $past(sel))
    else $error("up or down press did not swap prompt");
  a_sp_store: assert property (@(posedge clk_i) // [RULE9]
    disable iff (rst_i) store |=> state == setpoint_pkg::ST_SP_PROMPT
    && ($past(sel) ? sp2 : sp1) == $past(ebuf))
    else $error("setpoint not stored on enter");
  a_sp_load: assert property (@(posedge clk_i) // [RULE8]
    disable iff (rst_i) state == setpoint_pkg::ST_SP_PROMPT && !timeout
    && press == 5'h01 |=> state == setpoint_pkg::ST_SP_EDIT && digit == 2'h0
    && ebuf == (sel ? sp2 : sp1))
    else $error("select did not load setpoint");
  a_idle_exit: assert property (@(posedge clk_i) // [RULE7]
    disable iff (rst_i) timeout |=> state == setpoint_pkg::ST_DISPLAY)
    else $error("idle menu not abandoned");
  a_idle_clear: assert property (@(posedge clk_i) // [RULE19]
    disable iff (rst_i) any_press |=> idle_s == 5'h0 && sec_cnt == 32'h0)
    else $error("press did not restart idle count");
endmodule

// ### rtl/setpoint_pkg.sv
// Purpose: shared constants and types for the setpoint access menu
// Assumes: values are four packed decimal digits, most significant first
// Notes:   register offsets are byte addresses on the wishbone bus
package setpoint_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ       = 250_000_000;
  localparam int unsigned SEC_PERIOD_S = 1;
  localparam int unsigned SEC_CYCLES   = CLK_HZ * SEC_PERIOD_S;
  localparam int unsigned TIMEOUT_S    = 20;
  localparam int unsigned BLINK_MS     = 500;
  localparam int unsigned BLINK_CYCLES = (CLK_HZ / 1000) * BLINK_MS;

  // value layout
  localparam int unsigned DIGITS  = 4;
  localparam int unsigned DIG_W   = 4;
  localparam int unsigned VAL_W   = DIGITS * DIG_W;
  localparam int unsigned FULL_SC = 10000;
  localparam int unsigned SEGS    = 20;

  // register map
  localparam int unsigned ADR_W      = 5;
  localparam logic [4:0]  OFS_CTRL   = 5'h00;
  localparam logic [4:0]  OFS_CODE   = 5'h04;
  localparam logic [4:0]  OFS_SP1    = 5'h08;
  localparam logic [4:0]  OFS_SP2    = 5'h0c;
  localparam logic [4:0]  OFS_STATUS = 5'h10;

  // control fields
  localparam int unsigned CTRL_W       = 5;
  localparam int unsigned CTRL_ACCESS  = 0;
  localparam int unsigned CTRL_A1_LOW  = 1;
  localparam int unsigned CTRL_A2_HIGH = 2;
  localparam int unsigned CTRL_FMT_LO  = 3;
  localparam int unsigned CTRL_FMT_HI  = 4;

  // status fields
  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_SEL_BIT   = 3;
  localparam int unsigned ST_DIG_LSB   = 4;
  localparam int unsigned ST_BUF_LSB   = 16;

  // reset values
  localparam logic [4:0]  CTRL_RST = 5'h00;
  localparam logic [15:0] CODE_RST = 16'h0000;
  localparam logic [15:0] SP_RST   = 16'h0000;

  typedef enum {
    ST_DISPLAY,
    ST_CODE_PROMPT,
    ST_CODE_EDIT,
    ST_SP_PROMPT,
    ST_SP_EDIT
  } menu_state_t;
endpackage

// ### rtl/setpoint_bargraph.sv
// Purpose: bargraph rendering of live value against both setpoints
// Assumes: inputs are packed decimal, 0 to 9999 over the full scale
// Notes:   output segments are registered, blink_i sets flash phase
`timescale 1ns/100ps
module setpoint_bargraph #(
  parameter int unsigned SEGS = setpoint_pkg::SEGS
) (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic [15:0]     value_i,
  input  wire logic [15:0]     lo_i,
  input  wire logic [15:0]     hi_i,
  input  wire logic            a1_low_i,
  input  wire logic            a2_high_i,
  input  wire logic            fmt_lo_i,
  input  wire logic            fmt_hi_i,
  input  wire logic            blink_i,
  output logic      [SEGS-1:0] bar_o,
  output logic                 scale_on_o
);
  if (SEGS < 2 || SEGS > 255) $error("bargraph segment count out of range");

  // packed decimal to segment index
  function automatic logic [7:0] seg_idx(input logic [15:0] v);
    logic [31:0] b;
    b = 32'(v[15:12]) * 32'd1000 + 32'(v[11:8]) * 32'd100
      + 32'(v[7:4]) * 32'd10 + 32'(v[3:0]);
    return 8'((b * SEGS) / setpoint_pkg::FULL_SC);
  endfunction

  logic [7:0]      v_idx;
  logic [7:0]      lo_idx;
  logic [7:0]      hi_idx;
  logic            fmt;
  logic            valid;
  logic            adj;
  logic [SEGS-1:0] next_bar;
  logic            next_scale;

  // shared terms for all segments
  always_comb begin
    v_idx  = seg_idx(value_i);
    lo_idx = seg_idx(lo_i);
    hi_idx = seg_idx(hi_i);
    fmt    = fmt_lo_i | fmt_hi_i;
    valid  = fmt & a1_low_i & a2_high_i & (lo_i < hi_i); // [RULE15]
    adj    = (fmt_lo_i && v_idx == lo_idx)
           | (fmt_hi_i && v_idx == hi_idx);              // [RULE13]
    next_scale = (fmt && !valid) ? blink_i : 1'b1;        // [RULE16]
  end

  // one segment per index
  for (genvar i = 0; i < SEGS; i++) begin : g_seg
    logic in_lo;
    logic in_hi;
    logic is_bar;
    assign in_lo  = fmt_lo_i && 8'(i) < lo_idx;  // [RULE11] [RULE12]
    assign in_hi  = fmt_hi_i && 8'(i) > hi_idx;  // [RULE11] [RULE12]
    assign is_bar = 8'(i) == v_idx;
    assign next_bar[i] = !valid ? 1'b0 :         // [RULE16]
      in_lo  ? ((value_i == lo_i) ? blink_i : 1'b1) :  // [RULE14]
      in_hi  ? ((value_i == hi_i) ? blink_i : 1'b1) :  // [RULE14]
      is_bar ? (adj ? blink_i : 1'b1) : 1'b0;          // [RULE12]
  end

  // register the display drive
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bar_o      <= '0;
      scale_on_o <= 1'b1;
    end else begin
      bar_o      <= next_bar;
      scale_on_o <= next_scale;
    end
  end
endmodule

// ### verif/panel_operator.sv
// Purpose: operator model pressing the front panel buttons
// Assumes: one go pulse per press, mask names the buttons to press
// Notes:   bits 0..4 are select, up, down, right, enter
`timescale 1ns/100ps
module panel_operator (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       go_i,
  input  wire logic [4:0] mask_i,
  output logic      [4:0] btn_o
);
  logic [2:0] hold;
  logic [2:0] next_hold;
  logic [4:0] next_btn;

  // hold the buttons three cycles, then release them all
  always_comb begin
    next_hold = (hold != 3'h0) ? hold - 3'h1 : 3'h0;
    next_btn  = (hold > 3'h1) ? btn_o : 5'h00;
    if (go_i) begin
      next_hold = 3'h3;
      next_btn  = mask_i;
    end
  end

  // register button levels, released in reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold  <= 3'h0;
      btn_o <= 5'h00;
    end else begin
      hold  <= next_hold;
      btn_o <= next_btn;
    end
  end
endmodule

// ### verif/setpoint_access_menu_tb.sv
// Purpose: self-checking bench for the setpoint access menu
// Assumes: short second and blink counts keep the run brief
// Notes:   buttons come from the operator model, registers via wishbone
`timescale 1ns/100ps
module setpoint_access_menu_tb;
  localparam int unsigned SEC = 10;
  localparam logic [4:0] B_SEL = 5'h01;
  localparam logic [4:0] B_UP  = 5'h02;
  localparam logic [4:0] B_DN  = 5'h04;
  localparam logic [4:0] B_RT  = 5'h08;
  localparam logic [4:0] B_EN  = 5'h10;
  // ctrl, value, sp2, steady bars, flashing bars, scale {any, all}
  localparam logic [31:0] TBL [8][6] = '{
    '{32'h1f, 32'h5000, 32'h8000, 32'he040f, 32'h0, 32'h3},
    '{32'h1f, 32'h2100, 32'h8000, 32'he000f, 32'h10, 32'h3},
    '{32'h1f, 32'h2000, 32'h8000, 32'he0000, 32'h1f, 32'h3},
    '{32'h1f, 32'h8000, 32'h8000, 32'h0000f, 32'hf0000, 32'h3},
    '{32'h0f, 32'h5000, 32'h8000, 32'h0040f, 32'h0, 32'h3},
    '{32'h17, 32'h5000, 32'h8000, 32'he0400, 32'h0, 32'h3},
    '{32'h1d, 32'h5000, 32'h8000, 32'h0, 32'h0, 32'h2},
    '{32'h1f, 32'h5000, 32'h2000, 32'h0, 32'h0, 32'h2}};

  logic        clk   = 1'b0;
  logic        rst   = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [4:0]  adr   = 5'h00;
  logic [3:0]  sel   = 4'h0;
  logic [31:0] wdat  = 32'h0;
  logic [15:0] value = 16'h0000;
  logic        go    = 1'b0;
  logic [4:0]  mask  = 5'h00;
  logic [31:0] rdat;
  logic        ack;
  logic [4:0]  btn;
  logic [2:0]  state;
  logic [15:0] disp;
  logic [1:0]  digit;
  logic        edit;
  logic [19:0] bar;
  logic        scale;
  logic [31:0] rd;
  logic [19:0] b_and;
  logic [19:0] b_or;
  logic [1:0]  s_io;
  int          failures = 0;
  int          compares = 0;
  int          cycles = 0;

  setpoint_access_menu #(.SEC_CYCLES(SEC), .BLINK_CYCLES(4), .SEGS(20)) dut (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .btn_select_i(btn[0]),
    .btn_up_i(btn[1]), .btn_down_i(btn[2]), .btn_right_i(btn[3]),
    .btn_enter_i(btn[4]), .value_i(value), .menu_state_o(state),
    .disp_value_o(disp), .flash_digit_o(digit), .edit_active_o(edit),
    .bar_o(bar), .scale_on_o(scale));

  panel_operator op (.clk_i(clk), .rst_i(rst), .go_i(go), .mask_i(mask),
                     .btn_o(btn));

  // 250 MHz clock
  always #2 clk = ~clk;

  // cut a hang short
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 4000) begin
      failures = failures + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    compares = compares + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one classic wishbone cycle, held until ack is sampled at a rising edge
  task automatic wb(input logic w, input logic [4:0] a,
                    input logic [31:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hf;
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check("register", exp, rd);
  endtask

  // one press through the operator, then sample settled outputs
  task automatic press(input logic [4:0] m);
    @(posedge clk);
    mask <= m;
    go   <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (5) @(posedge clk);
    @(negedge clk);
  endtask

  // gather steady and flashing segments over three blink phases
  task automatic watch();
    repeat (3) @(negedge clk);
    b_and = bar;
    b_or  = bar;
    s_io  = {scale, scale};
    repeat (12) begin
      @(negedge clk);
      b_and = b_and & bar;
      b_or  = b_or | bar;
      s_io  = {s_io[1] | scale, s_io[0] & scale};
    end
  endtask

  initial begin
    int n;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    // reset values, unmapped place ignored
    check("scale", 32'h1, 32'(scale));
    wb(1'b1, 5'h14, 32'hffff);
    for (int a = 0; a < 24; a += 4) begin
      rchk(5'(a), 32'h0);
    end
    press(B_SEL | B_UP);
    check("state", 32'h0, 32'(state));
    $display("test reset and disabled entry finished");
    // open access, no code: prompts and setpoint edit
    wb(1'b1, setpoint_pkg::OFS_SP1, 32'h1234);
    wb(1'b1, setpoint_pkg::OFS_CTRL, 32'h1);
    press(B_SEL | B_UP);
    check("state", 32'h3, 32'(state));
    press(B_UP);
    rchk(setpoint_pkg::OFS_STATUS, 32'h000b);
    press(B_DN);
    rchk(setpoint_pkg::OFS_STATUS, 32'h0003);
    press(B_SEL);
    check("edit", 32'h11234, 32'({edit, disp}));
    press(B_UP);
    press(B_RT);
    press(B_DN);
    check("edit", 32'h12134, 32'({digit, disp}));
    press(B_EN);
    check("state", 32'h3, 32'(state));
    rchk(setpoint_pkg::OFS_SP1, 32'h2134);
    press(B_EN);
    check("state", 32'h0, 32'(state));
    $display("test direct setpoint edit finished");
    // code protected entry, right and value wrap
    wb(1'b1, setpoint_pkg::OFS_CODE, 32'h0001);
    rchk(setpoint_pkg::OFS_CODE, 32'h0001);
    press(B_SEL | B_UP);
    check("state", 32'h1, 32'(state));
    press(B_SEL);
    check("code", 32'h20000, 32'({state, disp}));
    press(B_DN);
    check("code", 32'h9000, 32'(disp));
    press(B_UP);
    repeat (3) press(B_RT);
    press(B_UP);
    check("code", 32'h30001, 32'({digit, disp}));
    press(B_RT);
    check("digit", 32'h0, 32'(digit));
    press(B_EN);
    check("state", 32'h3, 32'(state));
    press(B_EN);
    press(B_SEL | B_UP);
    press(B_SEL);
    press(B_EN);
    check("state", 32'h0, 32'(state));
    $display("test security code finished");
    // idle timeout, restarted by a press
    press(B_SEL | B_UP);
    repeat (15 * SEC) @(negedge clk);
    press(B_SEL);
    repeat (18 * SEC) @(negedge clk);
    check("state", 32'h2, 32'(state));
    n = 0;
    while (state !== 3'h0 && n < 4 * SEC) begin
      @(negedge clk);
      n = n + 1;
    end
    check("state", 32'h0, 32'(state));
    $display("test idle timeout finished");
    // bargraph formats, flashing and invalid settings
    wb(1'b1, setpoint_pkg::OFS_SP1, 32'h2000);
    for (int i = 0; i < 8; i++) begin
      wb(1'b1, setpoint_pkg::OFS_SP2, TBL[i][2]);
      wb(1'b1, setpoint_pkg::OFS_CTRL, TBL[i][0]);
      value <= TBL[i][1][15:0];
      watch();
      check("steady", TBL[i][3], 32'(b_and));
      check("flash", TBL[i][4], 32'(b_or & ~b_and));
      check("scale", TBL[i][5], 32'(s_io));
    end
    $display("test bargraph finished");
    give_verdict();
  end
endmodule
